// *** rtl/xbar_pkg.sv ***
// Constants shared by the priority pin crossbar files
package xbar_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PINS = 40;
    localparam int NUM_SKIP = 32;
    localparam int NUM_SIGS = 26;
    localparam int SIG_W = 5;
    localparam int ADDR_W = 6;
    localparam int NUM_PORTS = 5;
    localparam int NUM_FIXED = 4;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_ROUTE_A = 6'h00;
    localparam logic [5:0] OFF_ROUTE_B = 6'h01;
    localparam logic [5:0] OFF_ROUTE_C = 6'h02;
    localparam logic [5:0] OFF_SPI_CTRL = 6'h03;
    localparam logic [5:0] OFF_SKIP = 6'h04;
    localparam logic [5:0] OFF_IN_MODE = 6'h08;
    localparam logic [5:0] OFF_OUT_MODE = 6'h10;
    localparam logic [5:0] OFF_LATCH = 6'h18;
    localparam logic [5:0] OFF_EXT_CFG = 6'h20;
    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ROUTE = 8'h00;
    localparam logic [7:0] RST_SPI = 8'h00;
    localparam logic [7:0] RST_SKIP = 8'h00;
    localparam logic [7:0] RST_IN_MODE = 8'hff;
    localparam logic [7:0] RST_OUT_MODE = 8'h00;
    localparam logic [7:0] RST_LATCH = 8'hff;
    localparam logic [7:0] RST_EXT_CFG = 8'h00;
    localparam logic [7:0] MASK_ROUTE_B = 8'hfe;
    localparam logic [7:0] MASK_ROUTE_C = 8'hc1;
    localparam logic [7:0] MASK_SPI = 8'h03;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int A_UART = 0;
    localparam int A_CAN = 1;
    localparam int A_SPI = 2;
    localparam int A_SMB = 3;
    localparam int A_CMP = 4;
    localparam int B_CEX_LO = 2;
    localparam int B_SYSCLK = 1;
    localparam int B_ECI = 5;
    localparam int B_T0 = 6;
    localparam int B_T1 = 7;
    localparam int C_LIN = 0;
    localparam int C_ENABLE = 6;
    localparam int C_WEAK_PULLUP_DISABLE = 7;
    localparam logic [2:0] CEX_RESERVED = 3'h7;
    localparam logic [1:0] SS_THREE_WIRE = 2'h0;
    // ------------------------------------------------------------
    // Signal indices in priority order
    // ------------------------------------------------------------
    localparam int S_UART_TX = 0;
    localparam int S_SPI_SCK = 4;
    localparam int S_SPI_NSS = 7;
    localparam int S_SMB_SDA = 8;
    localparam int S_SMB_SCL = 9;
    localparam int S_CMP = 10;
    localparam int S_SYSCLK = 14;
    localparam int S_CEX0 = 15;
    localparam int S_ECI = 21;
    localparam int S_T0 = 22;
    localparam int S_T1 = 23;
    localparam int S_LIN_TX = 24;
    localparam int FIXED_PIN [NUM_FIXED] = '{4, 5, 6, 7};
endpackage

// *** rtl/route_if.sv ***
// Configuration and result of the pin allocator
`timescale 1ns/1ns
interface route_if;
    logic [xbar_pkg::NUM_PINS-1:0] skip;
    logic [xbar_pkg::NUM_SIGS-1:0] req;
    logic [xbar_pkg::NUM_PINS-1:0] owned;
    logic [xbar_pkg::SIG_W-1:0] owner [xbar_pkg::NUM_PINS];
    modport alloc (input skip, input req, output owned, output owner);
    modport user (output skip, output req, input owned, input owner);
endinterface

// *** rtl/route_allocator.sv ***
// Priority search that gives each requested signal a pin while free pins remain
`timescale 1ns/1ns
module route_allocator
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Allocation
    route_if.alloc rt
);
    logic [xbar_pkg::NUM_PINS-1:0] taken;
    logic [xbar_pkg::NUM_PINS-1:0] next_owned;
    logic [xbar_pkg::SIG_W-1:0] next_owner [xbar_pkg::NUM_PINS];
    logic found;

    // Fixed pins first, then lowest free pin per signal
    always_comb
    begin
        taken = rt.skip;
        next_owned = '0;
        found = 1'b0;
        for (int p = 0; p < xbar_pkg::NUM_PINS; p++)
            next_owner[p] = '0;
        for (int f = 0; f < xbar_pkg::NUM_FIXED; f++)
        begin
            if (rt.req[f])
            begin
                taken[xbar_pkg::FIXED_PIN[f]] = 1'b1;
                next_owned[xbar_pkg::FIXED_PIN[f]] = 1'b1;
                next_owner[xbar_pkg::FIXED_PIN[f]] = 5'(f);
            end
        end
        for (int s = xbar_pkg::NUM_FIXED; s < xbar_pkg::NUM_SIGS; s++)
        begin
            found = 1'b0;
            for (int p = 0; p < xbar_pkg::NUM_PINS; p++)
            begin
                if (rt.req[s] && !found && !taken[p])
                begin
                    taken[p] = 1'b1;
                    next_owned[p] = 1'b1;
                    next_owner[p] = 5'(s);
                    found = 1'b1;
                end
            end
        end
    end

    // Registered allocation result
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rt.owned <= '0;
            for (int p = 0; p < xbar_pkg::NUM_PINS; p++)
                rt.owner[p] <= '0;
        end
        else
        begin
            rt.owned <= next_owned;
            for (int p = 0; p < xbar_pkg::NUM_PINS; p++)
                rt.owner[p] <= next_owner[p];
        end
    end

    logic sda_on;
    logic scl_on;

    // Whether each two-wire signal sits on some pin, from the registered result
    always_comb
    begin
        sda_on = 1'b0;
        scl_on = 1'b0;
        for (int p = 0; p < xbar_pkg::NUM_PINS; p++)
        begin
            if (rt.owned[p] && rt.owner[p] == 5'(xbar_pkg::S_SMB_SDA))
                sda_on = 1'b1;
            if (rt.owned[p] && rt.owner[p] == 5'(xbar_pkg::S_SMB_SCL))
                scl_on = 1'b1;
        end
    end

    a_uart_fixed_pins: assert property (@(posedge clk) disable iff (rst)
        rt.req[0] |=> rt.owned[4] && rt.owner[4] == 5'd0 && rt.owned[5] && rt.owner[5] == 5'd1)
        else $error("serial port not on its fixed pins");
    a_can_fixed_pins: assert property (@(posedge clk) disable iff (rst)
        rt.req[2] |=> rt.owned[6] && rt.owner[6] == 5'd2 && rt.owned[7] && rt.owner[7] == 5'd3)
        else $error("fieldbus not on its fixed pins");
    a_skip_not_routed: assert property (@(posedge clk) disable iff (rst)
        ((rt.skip & 40'h00_0000_ff0f) != '0) |=> (($past(rt.skip) & rt.owned & 40'h00_0000_ff0f) == '0))
        else $error("skipped pin was routed");
    a_smb_pair_alloc: assert property (@(posedge clk) disable iff (rst)
        rt.req[xbar_pkg::S_SMB_SDA] |=> sda_on && scl_on)
        else $error("two-wire pair not placed together");
    a_first_lowest: assert property (@(posedge clk) disable iff (rst)
        rt.req[4] && rt.skip == '0 && rt.req[3:0] == 4'h0 |=> rt.owned[0] && rt.owner[0] == 5'd4)
        else $error("first signal not on lowest pin");
endmodule

// *** rtl/event_capture.sv ***
// Edge events on selectable pins of the second port
`timescale 1ns/1ns
module event_capture
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin view and setup
    input wire logic [7:0] pins,
    input wire logic [7:0] dig,
    input wire logic [7:0] cfg,
    // Events
    output logic [1:0] event_pulse,
    output logic wake
);
    logic [1:0] cur;
    logic [1:0] prev;
    logic [1:0] ok;

    // Selected pin level, polarity applied
    always_comb
    begin
        cur[0] = pins[cfg[2:0]] ~^ cfg[3];
        cur[1] = pins[cfg[6:4]] ~^ cfg[7];
        ok[0] = dig[cfg[2:0]];
        ok[1] = dig[cfg[6:4]];
    end

    // Edge detect to one-cycle events and wake
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev <= 2'h3; // Matches idle pin level so release gives no edge
            event_pulse <= 2'h0;
            wake <= 1'b0;
        end
        else
        begin
            prev <= cur;
            event_pulse <= cur & ~prev & ok;
            wake <= |(cur & ~prev & ok);
        end
    end

    sequence s_active_edge;
        !cur[0] && ok[0] ##1 cur[0] && ok[0] && $stable(cfg);
    endsequence
    a_edge_event: assert property (@(posedge clk) disable iff (rst)
        s_active_edge |=> event_pulse[0] && wake)
        else $error("edge gave no event");
    a_analog_no_event: assert property (@(posedge clk) disable iff (rst)
        !ok[0] |=> !event_pulse[0])
        else $error("event on analog pin");
endmodule

// *** rtl/priority_pin_crossbar.sv ***
// Priority pin crossbar: registers, routing, pad control
//
// Contract
// - Serial port fixed on pins 0.4/0.5
// - Fieldbus fixed on pins 0.6/0.7
// - Others take lowest free pin by priority
// - Assigned pins excluded from later searches
// - Skipped pins count as already taken
// - Two-wire pair allocated together
// - Unassigned pins stay plain port pins
// - Slave select only in four-wire mode
// - Matrix off: all pins plain inputs
// - Matrix off disables every output driver
// - Input mode 1 digital, resets digital
// - Analog pin: no pull, driver, receiver
// - Output mode applies to routed signals
// - Two-wire bus pins always open-drain
// - Pull-up on open-drain unless disabled
// - No pull-up while pin drives low
// - Pin edges raise event or wake
// - Events on digital pins, never analog
// - Last port has no skip bits
// - Three-bit count routes capture outputs ascending
// - Pull-up disable bit turns all off
`timescale 1ns/1ns
module priority_pin_crossbar
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Peripheral side, one bit per routed signal
    input wire logic [25:0] periph_out,
    input wire logic [25:0] periph_oe,
    output logic [25:0] periph_in,
    // Pads
    input wire logic [39:0] pad_in,
    output logic [39:0] pad_out,
    output logic [39:0] pad_oe,
    output logic [39:0] pad_pullup,
    output logic [39:0] pad_in_enable,
    // Events
    output logic [1:0] ext_event,
    output logic wake
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] routing_select_a;
    logic [7:0] routing_select_b;
    logic [7:0] routing_select_c;
    logic [7:0] spi_control_reg;
    logic [7:0] ext_interrupt_pin_config;
    logic [31:0] pin_skip_mask;
    logic [39:0] pin_input_mode;
    logic [39:0] pin_output_mode;
    logic [39:0] port_latch;
    logic [39:0] pad_meta;
    logic [39:0] pad_sync;
    logic [39:0] pad_view;
    logic [25:0] req;
    logic [7:0] next_rdata;
    logic [39:0] next_out;
    logic [39:0] next_oe;
    logic [39:0] next_pull;
    logic [25:0] next_periph_in;
    logic matrix_enable;
    logic weak_pullup_disable;
    logic [1:0] slave_select_mode;
    logic [2:0] capture_output_count;
    logic val;
    logic drv;
    logic od;
    logic [4:0] sig;
    route_if rt ();

    // Address of the n-th register of a group
    function automatic logic [5:0] reg_at(input logic [5:0] base, input int n);
        return base + 6'(n);
    endfunction

    // Two-wire bus signals are forced open-drain
    function automatic logic is_smb(input logic [4:0] s);
        return s == 5'(xbar_pkg::S_SMB_SDA) || s == 5'(xbar_pkg::S_SMB_SCL);
    endfunction

    assign matrix_enable = routing_select_c[xbar_pkg::C_ENABLE];
    assign weak_pullup_disable = routing_select_c[xbar_pkg::C_WEAK_PULLUP_DISABLE];
    assign slave_select_mode = spi_control_reg[1:0];
    assign capture_output_count = routing_select_b[xbar_pkg::B_CEX_LO +: 3];

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Routing and control registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            routing_select_a <= xbar_pkg::RST_ROUTE;
            routing_select_b <= xbar_pkg::RST_ROUTE;
            routing_select_c <= xbar_pkg::RST_ROUTE;
            spi_control_reg <= xbar_pkg::RST_SPI;
            ext_interrupt_pin_config <= xbar_pkg::RST_EXT_CFG;
        end
        else if (wr)
        begin
            case (addr)
                xbar_pkg::OFF_ROUTE_A: routing_select_a <= wdata;
                xbar_pkg::OFF_ROUTE_B: routing_select_b <= wdata & xbar_pkg::MASK_ROUTE_B;
                xbar_pkg::OFF_ROUTE_C: routing_select_c <= wdata & xbar_pkg::MASK_ROUTE_C;
                xbar_pkg::OFF_SPI_CTRL: spi_control_reg <= wdata & xbar_pkg::MASK_SPI;
                xbar_pkg::OFF_EXT_CFG: ext_interrupt_pin_config <= wdata;
                default: ;
            endcase
        end
    end

    // Per-port skip, mode and latch registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_skip_mask <= {4{xbar_pkg::RST_SKIP}};
            pin_input_mode <= {5{xbar_pkg::RST_IN_MODE}};
            pin_output_mode <= {5{xbar_pkg::RST_OUT_MODE}};
            port_latch <= {5{xbar_pkg::RST_LATCH}};
        end
        else if (wr)
        begin
            for (int n = 0; n < xbar_pkg::NUM_PORTS; n++)
            begin
                if (n < 4 && addr == reg_at(xbar_pkg::OFF_SKIP, n))
                    pin_skip_mask[n*8 +: 8] <= wdata;
                if (addr == reg_at(xbar_pkg::OFF_IN_MODE, n))
                    pin_input_mode[n*8 +: 8] <= wdata;
                if (addr == reg_at(xbar_pkg::OFF_OUT_MODE, n))
                    pin_output_mode[n*8 +: 8] <= wdata;
                if (addr == reg_at(xbar_pkg::OFF_LATCH, n))
                    port_latch[n*8 +: 8] <= wdata;
            end
        end
    end

    // Read mux; the latch offsets read the pad levels
    always_comb
    begin
        next_rdata = 8'h00;
        case (addr)
            xbar_pkg::OFF_ROUTE_A: next_rdata = routing_select_a;
            xbar_pkg::OFF_ROUTE_B: next_rdata = routing_select_b;
            xbar_pkg::OFF_ROUTE_C: next_rdata = routing_select_c;
            xbar_pkg::OFF_SPI_CTRL: next_rdata = spi_control_reg;
            xbar_pkg::OFF_EXT_CFG: next_rdata = ext_interrupt_pin_config;
            default: next_rdata = 8'h00;
        endcase
        for (int n = 0; n < xbar_pkg::NUM_PORTS; n++)
        begin
            if (n < 4 && addr == reg_at(xbar_pkg::OFF_SKIP, n))
                next_rdata = pin_skip_mask[n*8 +: 8];
            if (addr == reg_at(xbar_pkg::OFF_IN_MODE, n))
                next_rdata = pin_input_mode[n*8 +: 8];
            if (addr == reg_at(xbar_pkg::OFF_OUT_MODE, n))
                next_rdata = pin_output_mode[n*8 +: 8];
            if (addr == reg_at(xbar_pkg::OFF_LATCH, n))
                next_rdata = pad_view[n*8 +: 8];
        end
    end

    // Read data register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (rd)
            rdata <= next_rdata;
        else
            rdata <= 8'h00;
    end

    // ------------------------------------------------------------
    // Allocation requests
    // ------------------------------------------------------------
    // Request vector in priority order
    always_comb
    begin
        req = '0;
        req[1:0] = {2{routing_select_a[xbar_pkg::A_UART]}};
        req[3:2] = {2{routing_select_a[xbar_pkg::A_CAN]}};
        req[6:4] = {3{routing_select_a[xbar_pkg::A_SPI]}};
        req[xbar_pkg::S_SPI_NSS] = routing_select_a[xbar_pkg::A_SPI]
            && slave_select_mode != xbar_pkg::SS_THREE_WIRE;
        req[9:8] = {2{routing_select_a[xbar_pkg::A_SMB]}};
        req[xbar_pkg::S_CMP +: 4] = routing_select_a[xbar_pkg::A_CMP +: 4];
        req[xbar_pkg::S_SYSCLK] = routing_select_b[xbar_pkg::B_SYSCLK];
        for (int k = 0; k < 6; k++)
            req[xbar_pkg::S_CEX0 + k] = capture_output_count != xbar_pkg::CEX_RESERVED
                && capture_output_count > 3'(k);
        req[xbar_pkg::S_ECI] = routing_select_b[xbar_pkg::B_ECI];
        req[xbar_pkg::S_T0] = routing_select_b[xbar_pkg::B_T0];
        req[xbar_pkg::S_T1] = routing_select_b[xbar_pkg::B_T1];
        req[xbar_pkg::S_LIN_TX +: 2] = {2{routing_select_c[xbar_pkg::C_LIN]}};
    end

    assign rt.req = req;
    assign rt.skip = {8'h00, pin_skip_mask};

    route_allocator u_alloc
    (
        .clk(clk),
        .rst(rst),
        .rt(rt)
    );

    // ------------------------------------------------------------
    // Pads
    // ------------------------------------------------------------
    // Two-stage synchroniser on pad inputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pad_meta <= '0;
            pad_sync <= '0;
        end
        else
        begin
            pad_meta <= pad_in;
            pad_sync <= pad_meta;
        end
    end

    assign pad_view = pad_sync & pin_input_mode;

    // Driver, value and pull-up per pin
    always_comb
    begin
        val = 1'b0;
        drv = 1'b0;
        od = 1'b0;
        sig = '0;
        next_out = '0;
        next_oe = '0;
        next_pull = '0;
        for (int p = 0; p < xbar_pkg::NUM_PINS; p++)
        begin
            sig = rt.owner[p];
            val = rt.owned[p] ? periph_out[sig] : port_latch[p];
            drv = rt.owned[p] ? periph_oe[sig] : 1'b1;
            od = !pin_output_mode[p] || (rt.owned[p] && is_smb(sig));
            next_oe[p] = matrix_enable && pin_input_mode[p] && drv && !(od && val);
            next_out[p] = val && !od;
            next_pull[p] = pin_input_mode[p] && !weak_pullup_disable
                && !(next_oe[p] && !next_out[p]) && !(next_oe[p] && !od);
        end
    end

    // Routed pad levels back to peripherals, idle high
    always_comb
    begin
        next_periph_in = '1;
        for (int p = 0; p < xbar_pkg::NUM_PINS; p++)
            if (matrix_enable && rt.owned[p])
                next_periph_in[rt.owner[p]] = pad_view[p];
    end

    // Registered pad control
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pad_out <= '0;
            pad_oe <= '0;
            pad_pullup <= '0;
            pad_in_enable <= '0;
            periph_in <= '1;
        end
        else
        begin
            pad_out <= next_out;
            pad_oe <= next_oe;
            pad_pullup <= next_pull;
            pad_in_enable <= pin_input_mode;
            periph_in <= next_periph_in;
        end
    end

    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    event_capture u_events
    (
        .clk(clk),
        .rst(rst),
        .pins(pad_view[15:8]),
        .dig(pin_input_mode[15:8]),
        .cfg(ext_interrupt_pin_config),
        .event_pulse(ext_event),
        .wake(wake)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [39:0] smb_pins;
    logic nss_on;

    // Pins holding two-wire signals, and whether slave select got a pin
    always_comb
    begin
        smb_pins = '0;
        nss_on = 1'b0;
        for (int p = 0; p < xbar_pkg::NUM_PINS; p++)
        begin
            smb_pins[p] = rt.owned[p] && is_smb(rt.owner[p]);
            if (rt.owned[p] && rt.owner[p] == 5'(xbar_pkg::S_SPI_NSS))
                nss_on = 1'b1;
        end
    end

    a_disabled_no_drive: assert property (@(posedge clk) disable iff (rst)
        !matrix_enable |=> pad_oe == '0)
        else $error("driver on while matrix disabled");
    a_analog_pin_quiet: assert property (@(posedge clk) disable iff (rst)
        ##1 ((pad_oe | pad_pullup | pad_in_enable) & ~$past(pin_input_mode)) == '0)
        else $error("analog pin not isolated");
    a_smb_open_drain: assert property (@(posedge clk) disable iff (rst)
        (pad_out & $past(smb_pins)) == '0)
        else $error("two-wire pin driven high");
    a_pullup_off_low: assert property (@(posedge clk) disable iff (rst)
        (pad_oe & ~pad_out & pad_pullup) == '0)
        else $error("pull-up on while driving low");
    a_weak_pullup_disable_all_off: assert property (@(posedge clk) disable iff (rst)
        weak_pullup_disable |=> pad_pullup == '0)
        else $error("pull-up left on when disabled");
    a_disabled_pullup: assert property (@(posedge clk) disable iff (rst)
        !matrix_enable && !weak_pullup_disable |=> pad_pullup == $past(pin_input_mode))
        else $error("input pin lost its pull-up");
    a_three_wire_nss: assert property (@(posedge clk) disable iff (rst)
        slave_select_mode == xbar_pkg::SS_THREE_WIRE |=> !nss_on)
        else $error("slave select routed in three-wire mode");
endmodule

// *** tb/board_model.sv ***
// Board logic that resolves each pad from every driver
`timescale 1ns/1ns
module board_model
(
    // Clock
    input wire logic clk,
    // Crossbar pad side
    input wire logic [39:0] pad_out,
    input wire logic [39:0] pad_oe,
    input wire logic [39:0] pad_pullup,
    // Bench drive
    input wire logic [39:0] ext_en,
    input wire logic [39:0] ext_val,
    output logic [39:0] pad_in
);
    logic flip = 1'b0;
    // Floating pads toggle so no stale level hides a fault
    always @(posedge clk)
    begin
        flip <= ~flip;
    end
    // Wire level: device driver, then board driver, then pull-up
    always_comb
    begin
        for (int i = 0; i < 40; i++)
        begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pullup[i] | flip;
        end
    end
endmodule

// *** tb/test_priority_pin_crossbar.sv ***
// Self-checking bench for the priority pin crossbar
`timescale 1ns/1ns
module test_priority_pin_crossbar;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [25:0] periph_out = 26'h3ff_ffff;
    logic [25:0] periph_oe = 26'h3ff_ffff;
    logic [25:0] periph_in;
    logic [39:0] pad_in, pad_out, pad_oe, pad_pullup, pad_in_enable, smb, one;
    logic [39:0] ext_en = 40'h00_0000_0000;
    logic [39:0] ext_val = 40'h00_0000_0000;
    logic [1:0] ext_event;
    logic wake;
    logic [1:0] got;
    logic [7:0] ra, rb, rc, sk [4];
    logic [1:0] ssm;
    int num_errors = 0;
    int check_count = 0;
    int pinof [26];
    priority_pin_crossbar u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .pad_in_enable(pad_in_enable), .ext_event(ext_event), .wake(wake));
    board_model u_board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    // Clock
    initial forever #20 clk = ~clk;
    // Compare and count
    task chk(input logic [39:0] seen, input logic [39:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Register port cycles
    task wreg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [5:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({32'h0000_0000, rdata}, {32'h0000_0000, exp}, what);
    endtask
    // Reference allocator: fixed pairs, then lowest free pin in priority order
    task alloc();
        logic [39:0] taken;
        logic [25:0] en;
        int n;
        n = (rb[4:2] == 3'h7) ? 0 : int'(rb[4:2]);
        en = {{2{rc[0]}}, rb[7:5], 6'(~(6'h3f << n)), rb[1], ra[7:4], {2{ra[3]}}, (ssm != 2'h0) & ra[2],
            {3{ra[2]}}, {2{ra[1]}}, {2{ra[0]}}};
        taken = {8'h00, sk[3], sk[2], sk[1], sk[0]} | {32'h0000_0000, ra[1], ra[1], ra[0], ra[0], 4'h0};
        smb = '0;
        for (int s = 0; s < 26; s++)
        begin
            pinof[s] = (en[s] && s < 4) ? s + 4 : -1;
            for (int p = 0; p < 40 && en[s] && s >= 4 && pinof[s] < 0; p++)
            begin
                if (!taken[p])
                begin
                    pinof[s] = p;
                    taken[p] = 1'b1;
                end
            end
            if ((s == 8 || s == 9) && pinof[s] >= 0)
                smb[pinof[s]] = 1'b1;
        end
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(16586));
        cyc(4);
        rst <= 1'b0;
        cyc(2);
        chk(pad_in_enable, '1, "digital at reset");
        chk(pad_oe, '0, "no drive at reset");
        rreg(xbar_pkg::OFF_IN_MODE, 8'hff, "input mode");
        wreg(xbar_pkg::OFF_ROUTE_B, 8'hff);
        rreg(xbar_pkg::OFF_ROUTE_B, 8'hfe, "reserved bit");
        rreg(6'h3f, 8'h00, "unmapped");
        $display("register test done");
        for (int t = 0; t < 5; t++)
        begin
            ra = 8'($urandom);
            rb = 8'($urandom) & 8'hfe;
            rc = 8'($urandom) & 8'h81;
            ssm = 2'($urandom);
            for (int i = 0; i < 4; i++)
                sk[i] = 8'($urandom) & 8'($urandom);
            sk[0] = sk[0] | 8'h03;
            wreg(xbar_pkg::OFF_ROUTE_C, 8'h00);
            for (int i = 0; i < 5; i++)
                wreg(xbar_pkg::OFF_OUT_MODE + 6'(i), 8'hff);
            for (int i = 0; i < 4; i++)
                wreg(xbar_pkg::OFF_SKIP + 6'(i), sk[i]);
            wreg(xbar_pkg::OFF_SPI_CTRL, {6'h00, ssm});
            wreg(xbar_pkg::OFF_ROUTE_A, ra);
            wreg(xbar_pkg::OFF_ROUTE_B, rb);
            wreg(xbar_pkg::OFF_ROUTE_C, rc);
            cyc(3);
            chk(pad_oe, '0, "drive while off");
            chk({14'h0000, periph_in}, {14'h0000, 26'h3ff_ffff}, "inputs while off");
            wreg(xbar_pkg::OFF_ROUTE_C, rc | 8'h40);
            alloc();
            for (int s = 0; s < 26; s++)
            begin
                @(posedge clk);
                periph_out <= ~(26'h1 << s);
                cyc(4);
                one = (pinof[s] < 0) ? '0 : 40'h1 << pinof[s];
                chk({39'h0, periph_in[s]}, {39'h0, pinof[s] < 0}, "routed input");
                chk(pad_out, ~smb & ~one, "pad level");
                chk(pad_oe, ~(smb & ~one), "pad drive");
                chk(pad_pullup, rc[7] ? '0 : smb & ~one, "pull-up");
            end
            periph_out <= '1;
            $display("routing test %0d done", t);
        end
        wreg(xbar_pkg::OFF_IN_MODE + 6'h04, 8'h00);
        cyc(3);
        chk({16'h0000, pad_in_enable[39:32], pad_oe[39:32], pad_pullup[39:32]}, '0, "analog pins");
        wreg(xbar_pkg::OFF_OUT_MODE + 6'h01, 8'h00);
        wreg(xbar_pkg::OFF_EXT_CFG, 8'h0b);
        // Board holds the second event pin high so only the first one moves
        ext_en <= 40'h00_0000_0900;
        ext_val <= 40'h00_0000_0100;
        for (int k = 0; k < 2; k++)
        begin
            cyc(6);
            ext_val <= 40'h00_0000_0900;
            got = 2'h0;
            repeat (8)
            begin
                cyc(1);
                got = got | {wake === 1'b1, ext_event[0] === 1'b1};
            end
            chk({39'h0, got[0]}, {39'h0, k == 0}, "pin event");
            chk({39'h0, got[1]}, {39'h0, k == 0}, "wake");
            ext_val <= 40'h00_0000_0100;
            wreg(xbar_pkg::OFF_IN_MODE + 6'h01, 8'hf7);
        end
        $display("event test done");
        end_sim();
    end
endmodule
